// file: src/tmu_pkg.sv
// constants and types shared by the trigger mode unit
package tmu_pkg;

    // register offsets (printed values are register numbers, not all multiples of four)
    localparam logic [31:0] TMU_IDX_BOARD_COMMAND   = 32'h0000_0000;
    localparam logic [31:0] TMU_IDX_TRIG_SRC_SEL    = 32'h0000_9C40;
    localparam logic [31:0] TMU_IDX_TRIG_OUT_EN     = 32'h0000_9CA4;
    localparam logic [31:0] TMU_IDX_TRIG_IN_LOAD    = 32'h0000_9CAE;
    localparam logic [31:0] TMU_IDX_STATUS          = 32'h0000_9D00;

    // mode codes written to trigger_source_select
    localparam logic [31:0] TMU_IMMEDIATE_START_MODE = 32'h0000_0000;
    localparam logic [31:0] TMU_RISING_EDGE_MODE     = 32'h0000_4E20;
    localparam logic [31:0] TMU_FALLING_EDGE_MODE    = 32'h0000_4E2A;
    localparam logic [31:0] TMU_ANY_EDGE_MODE        = 32'h0000_4E3E;

    // board command codes
    localparam logic [31:0] TMU_CMD_START              = 32'h0000_0001;
    localparam logic [31:0] TMU_CMD_STOP               = 32'h0000_0002;
    localparam logic [31:0] TMU_FORCE_TRIGGER_CODE     = 32'h0000_0010;

    // reset values
    localparam logic [31:0] TMU_MODE_RST     = TMU_IMMEDIATE_START_MODE;
    localparam logic        TMU_OUT_EN_RST   = 1'b0;
    localparam logic        TMU_LOAD_RST     = 1'b0;

    // status register field positions
    localparam int TMU_ST_ARMED_BIT   = 0;
    localparam int TMU_ST_REPLAY_BIT  = 1;
    localparam int TMU_ST_RUN_BIT     = 2;
    localparam int TMU_ST_LEVEL_BIT   = 3;

    // timing: setup time before an immediate start, and trigger output pulse width
    localparam int TMU_SETUP_NS       = 40;
    localparam int TMU_CLK_PERIOD_NS  = 10;
    localparam int TMU_SETUP_CYC      = (TMU_SETUP_NS + TMU_CLK_PERIOD_NS - 1) / TMU_CLK_PERIOD_NS;
    localparam int TMU_PULSE_NS       = 40;
    localparam int TMU_PULSE_CYC      = TMU_PULSE_NS / TMU_CLK_PERIOD_NS;
    localparam int TMU_SYNC_STAGES    = 2;

    typedef enum logic [2:0] {
        TMU_IDLE,
        TMU_SETUP,
        TMU_ARMED,
        TMU_REPLAY,
        TMU_REARM
    } tmu_state_t;

endpackage : tmu_pkg

// file: src/tmu_edge_detect.sv
// synchroniser and edge detector for the external trigger input
`timescale 1ns/10ps
module tmu_edge_detect
    import tmu_pkg::*;
(
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic clk_en,
    // raw input
    input  wire logic async_in,
    // synchronised outputs
    output logic      level,
    output logic      rise,
    output logic      fall
);

    typedef struct packed {
        logic [TMU_SYNC_STAGES-1:0] sync;
        logic                       prev;
    } tmu_ed_state_t;

    tmu_ed_state_t st_r;
    tmu_ed_state_t st_nxt;

    //////////////////////////////////////////////////////////////////////////
    // two-stage synchroniser
    always_comb begin
        st_nxt      = st_r;
        st_nxt.sync = {st_r.sync[TMU_SYNC_STAGES-2:0], async_in};
        st_nxt.prev = st_r.sync[TMU_SYNC_STAGES-1];
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_r <= '0;
        end else if (clk_en) begin
            st_r <= st_nxt;
        end
    end

    // edges only look at the last stage, never the first
    assign level = st_r.sync[TMU_SYNC_STAGES-1];
    assign rise  = st_r.sync[TMU_SYNC_STAGES-1] & ~st_r.prev;
    assign fall  = ~st_r.sync[TMU_SYNC_STAGES-1] & st_r.prev;

endmodule : tmu_edge_detect

// file: src/tmu_trigger_mode_unit.sv
// trigger mode unit: mode selection, edge triggering, force trigger and trigger output
//
// Added by the designer: the strobed register port.
`timescale 1ns/10ps
module tmu_trigger_mode_unit
    import tmu_pkg::*;
(
    // clock, reset, enable
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    // register port
    input  wire logic [31:0] reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // replay engine
    input  wire logic        replay_done,
    output logic             replay_start,
    // external trigger connector
    input  wire logic        trig_in,
    output logic             trig_out,
    output logic             trig_out_oe,
    output logic             trig_in_load_en
);

    typedef struct packed {
        logic [31:0] mode;
        logic        out_en;
        logic        load;
        tmu_state_t  fsm;
        logic [7:0]  cnt;
        logic [7:0]  pulse_cnt;
        logic        start_p;
        logic [31:0] rdata;
    } tmu_state_all_t;

    tmu_state_all_t st_r;
    tmu_state_all_t st_nxt;

    logic in_level;
    logic in_rise;
    logic in_fall;

    //////////////////////////////////////////////////////////////////////////
    tmu_edge_detect u_edge (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .clk_en   (clk_en),
        .async_in (trig_in),
        .level    (in_level),
        .rise     (in_rise),
        .fall     (in_fall)
    );

    //////////////////////////////////////////////////////////////////////////
    logic ext_mode;
    logic edge_hit;
    logic wr_cmd;
    logic force_hit;
    logic [31:0] status;

    always_comb begin
        ext_mode = (st_r.mode == TMU_RISING_EDGE_MODE) || (st_r.mode == TMU_FALLING_EDGE_MODE)
                   || (st_r.mode == TMU_ANY_EDGE_MODE);
        case (st_r.mode)
            TMU_RISING_EDGE_MODE: edge_hit = in_rise;
            TMU_FALLING_EDGE_MODE: edge_hit = in_fall;
            TMU_ANY_EDGE_MODE: edge_hit = in_rise | in_fall;
            default: edge_hit = 1'b0;
        endcase
        wr_cmd    = reg_wr && (reg_addr == TMU_IDX_BOARD_COMMAND);
        force_hit = wr_cmd && (reg_wdata == TMU_FORCE_TRIGGER_CODE);
        status    = '0;
        status[TMU_ST_ARMED_BIT]  = (st_r.fsm == TMU_ARMED);
        status[TMU_ST_REPLAY_BIT] = (st_r.fsm == TMU_REPLAY);
        status[TMU_ST_RUN_BIT]    = (st_r.fsm != TMU_IDLE);
        status[TMU_ST_LEVEL_BIT]  = in_level;
    end

    //////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_nxt         = st_r;
        st_nxt.start_p = 1'b0;
        if (st_r.pulse_cnt != 8'h00) begin
            st_nxt.pulse_cnt = st_r.pulse_cnt - 8'h01;
        end

        // register writes
        if (reg_wr) begin
            case (reg_addr)
                TMU_IDX_TRIG_SRC_SEL: st_nxt.mode = reg_wdata;
                TMU_IDX_TRIG_OUT_EN:  st_nxt.out_en = reg_wdata[0];
                TMU_IDX_TRIG_IN_LOAD: st_nxt.load = reg_wdata[0];
                default: ;
            endcase
        end

        // register reads, data one cycle later
        st_nxt.rdata = '0;
        if (reg_rd) begin
            case (reg_addr)
                TMU_IDX_BOARD_COMMAND: st_nxt.rdata = '0;
                TMU_IDX_TRIG_SRC_SEL:  st_nxt.rdata = st_r.mode;
                TMU_IDX_TRIG_OUT_EN:   st_nxt.rdata = {31'h0000_0000, st_r.out_en};
                TMU_IDX_TRIG_IN_LOAD:  st_nxt.rdata = {31'h0000_0000, st_r.load};
                TMU_IDX_STATUS:        st_nxt.rdata = status;
                default:               st_nxt.rdata = '0;
            endcase
        end

        case (st_r.fsm)
            TMU_IDLE: begin
                if (wr_cmd && reg_wdata == TMU_CMD_START) begin
                    st_nxt.fsm = TMU_SETUP;
                    st_nxt.cnt = 8'(TMU_SETUP_CYC - 1);
                end
            end
            TMU_SETUP: begin
                if (st_r.cnt != 8'h00) begin
                    st_nxt.cnt = st_r.cnt - 8'h01;
                end else if (st_r.mode == TMU_IMMEDIATE_START_MODE) begin
                    st_nxt.fsm     = TMU_REPLAY;
                    st_nxt.start_p = 1'b1;
                end else begin
                    // arm now, older edges never seen
                    st_nxt.fsm = TMU_ARMED;
                end
            end
            TMU_ARMED: begin
                if (edge_hit || force_hit) begin
                    st_nxt.fsm     = TMU_REPLAY;
                    st_nxt.start_p = 1'b1;
                    if (ext_mode || st_r.out_en) begin
                        st_nxt.pulse_cnt = 8'(TMU_PULSE_CYC);
                    end
                end
            end
            TMU_REPLAY: begin
                if (replay_done) begin
                    st_nxt.fsm = TMU_REARM;
                end
            end
            TMU_REARM: begin
                if (st_r.mode == TMU_IMMEDIATE_START_MODE) begin
                    st_nxt.fsm = TMU_IDLE;
                end else begin
                    st_nxt.fsm = TMU_ARMED;
                end
            end
            default: st_nxt.fsm = TMU_IDLE;
        endcase

        // stop always wins the next state, back to idle; a start or output pulse set in the same cycle still goes out
        if (wr_cmd && reg_wdata == TMU_CMD_STOP) begin
            st_nxt.fsm = TMU_IDLE;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_r.mode      <= TMU_MODE_RST;
            st_r.out_en    <= TMU_OUT_EN_RST;
            st_r.load      <= TMU_LOAD_RST;
            st_r.fsm       <= TMU_IDLE;
            st_r.cnt       <= 8'h00;
            st_r.pulse_cnt <= 8'h00;
            st_r.start_p   <= 1'b0;
            st_r.rdata     <= 32'h0000_0000;
        end else if (clk_en) begin
            st_r <= st_nxt;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    assign reg_rdata       = st_r.rdata;
    assign replay_start    = st_r.start_p;
    // immediate-mode starts never load the pulse counter
    assign trig_out        = (st_r.pulse_cnt != 8'h00);
    // driver enable follows mode or register
    assign trig_out_oe     = ext_mode || st_r.out_en;
    assign trig_in_load_en = st_r.load;

endmodule : tmu_trigger_mode_unit

// file: verif/tmu_trigger_mode_unit_asserts.sv
// port assertions for the trigger mode unit
`timescale 1ns/10ps
module tmu_unit_chk
    import tmu_pkg::*;
(
    // clock and register port
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic        clk_en,
    input wire logic [31:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    // trigger side
    input wire logic        replay_done,
    input wire logic        replay_start,
    input wire logic        trig_in,
    input wire logic        trig_out,
    input wire logic        trig_out_oe,
    input wire logic        trig_in_load_en
);
    logic [31:0] mode_r;
    logic        oen_r;
    logic        ext;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // shadow copies, so output checks never rely on a read-back
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            mode_r <= TMU_MODE_RST;
            oen_r  <= TMU_OUT_EN_RST;
        end else if (reg_wr && clk_en && reg_addr == TMU_IDX_TRIG_SRC_SEL) begin
            mode_r <= reg_wdata;
        end else if (reg_wr && clk_en && reg_addr == TMU_IDX_TRIG_OUT_EN) begin
            oen_r <= reg_wdata[0];
        end
    end
    assign ext = mode_r == TMU_RISING_EDGE_MODE || mode_r == TMU_FALLING_EDGE_MODE || mode_r == TMU_ANY_EDGE_MODE;
    chk_start_single:
        assert property (replay_start |=> !replay_start) else $error("start pulse too long");
    chk_out_width:
        assert property ($rose(trig_out) |-> trig_out[*4] ##1 !trig_out) else $error("bad output pulse");
    chk_out_mode:
        assert property ($rose(trig_out) |-> (ext || oen_r) && replay_start && mode_r != TMU_IMMEDIATE_START_MODE)
            else $error("output pulse without enabled edge or forced trigger");
    chk_oe_ext:
        assert property (ext |-> trig_out_oe) else $error("driver off in edge mode");
    chk_oe_reg:
        assert property (oen_r |-> trig_out_oe) else $error("driver off while enabled");
    chk_oe_off:
        assert property (!ext && !oen_r |-> !trig_out_oe) else $error("driver on while disabled");
    chk_load_set:
        assert property (reg_wr && clk_en && reg_addr == TMU_IDX_TRIG_IN_LOAD && reg_wdata[0] |-> ##[1:2] trig_in_load_en)
            else $error("termination not switched in");
    chk_sync_lat:
        assert property (replay_start && ext && !$past(reg_wr) |-> $past(trig_in, 3) != $past(trig_in, 4))
            else $error("edge trigger latency wrong");
endmodule : tmu_unit_chk

bind tmu_trigger_mode_unit tmu_unit_chk u_tmu_unit_chk (
    .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .replay_done(replay_done),
    .replay_start(replay_start), .trig_in(trig_in), .trig_out(trig_out), .trig_out_oe(trig_out_oe),
    .trig_in_load_en(trig_in_load_en));

// file: verif/tmu_far_side.sv
// far side model: trigger source level and replay engine
`timescale 1ns/10ps
module tmu_far_side #(
    parameter int REPLAY_CYC = 12
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // trigger source and replay handshake
    input wire logic src_level,
    input wire logic replay_start,
    output logic     trig_in,
    output logic     replay_done
);
    int cnt = 0;
    assign trig_in = src_level;
    // replay runs long enough that edges can land while it is busy
    always @(posedge ref_clk) begin
        replay_done <= rst_n && cnt == 1;
        cnt <= (!rst_n || cnt == 0) ? (replay_start ? REPLAY_CYC : 0) : cnt - 1;
    end
endmodule : tmu_far_side

// file: verif/tb_trigger_mode_unit.sv
// self-checking bench for the trigger mode unit
`timescale 1ns/10ps
module tb_trigger_mode_unit;
    import tmu_pkg::*;
    logic        ref_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [31:0] reg_addr = 32'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        lvl = 1'b0;
    logic [31:0] reg_rdata;
    logic        replay_done, replay_start, trig_in, trig_out, trig_out_oe, trig_in_load_en;
    int          n_mismatch = 0;
    int          comparisons = 0;
    logic [31:0] modes [3] = '{TMU_RISING_EDGE_MODE, TMU_FALLING_EDGE_MODE, TMU_ANY_EDGE_MODE};
    always #5 ref_clk = ~ref_clk;
    tmu_trigger_mode_unit u_tmu_trigger_mode_unit (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(1'b1),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .replay_done(replay_done), .replay_start(replay_start), .trig_in(trig_in), .trig_out(trig_out),
        .trig_out_oe(trig_out_oe), .trig_in_load_en(trig_in_load_en));
    tmu_far_side u_tmu_far_side (.ref_clk(ref_clk), .rst_n(rst_n), .src_level(lvl), .trig_in(trig_in),
        .replay_start(replay_start), .replay_done(replay_done));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic final_report();
        $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        chk(reg_rdata, exp);
        @(posedge ref_clk);
    endtask : rd
    // idle cycles until replay starts; a negative figure means none may come
    task automatic wait_start(input int exp, input logic out);
        int n;
        for (n = 0; n < 20; n++) begin
            @(negedge ref_clk);
            if (replay_start === 1'b1) begin
                chk({31'h0, trig_out}, {31'h0, out});
                break;
            end
        end
        @(posedge ref_clk);
        chk(32'(n), exp < 0 ? 32'd20 : 32'(exp));
        if (exp >= 0 && n == 20)
            final_report();
    endtask : wait_start
    // toggle the source; a qualifying edge is followed by toggles during replay
    task automatic edge_step(input int m);
        logic q;
        q = (m == 2) || ((m == 0) == !lvl);
        lvl <= ~lvl;
        @(posedge ref_clk);
        // the edge needs one cycle per synchroniser stage before the start pulse shows
        wait_start(q ? TMU_SYNC_STAGES : -1, q);
        if (q) begin
            lvl <= ~lvl;
            repeat (2) @(posedge ref_clk);
            lvl <= ~lvl;
            wait_start(-1, 1'b0);
        end
    endtask : edge_step
    initial begin
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(TMU_IDX_TRIG_SRC_SEL, TMU_MODE_RST);
        rd(32'h0000_1234, 32'h0);
        wr(TMU_IDX_TRIG_IN_LOAD, 32'h1);
        rd(TMU_IDX_TRIG_IN_LOAD, 32'h1);
        chk({31'h0, trig_in_load_en}, 32'h1);
        wr(TMU_IDX_TRIG_OUT_EN, 32'h1);
        rd(TMU_IDX_TRIG_OUT_EN, 32'h1);
        chk({31'h0, trig_out_oe}, 32'h1);
        wr(TMU_IDX_BOARD_COMMAND, TMU_CMD_START);
        wait_start(TMU_SETUP_CYC, 1'b0);
        repeat (20) @(posedge ref_clk);
        wr(TMU_IDX_BOARD_COMMAND, TMU_FORCE_TRIGGER_CODE);
        wait_start(-1, 1'b0);
        wr(TMU_IDX_TRIG_OUT_EN, 32'h0);
        rd(TMU_IDX_TRIG_OUT_EN, 32'h0);
        chk({31'h0, trig_out_oe}, 32'h0);
        $display("register and immediate tests done");
        foreach (modes[m]) begin
            wr(TMU_IDX_TRIG_SRC_SEL, modes[m]);
            lvl <= ~lvl;
            repeat (4) @(posedge ref_clk);
            chk({31'h0, trig_out_oe}, 32'h1);
            wr(TMU_IDX_BOARD_COMMAND, TMU_CMD_START);
            wait_start(-1, 1'b0);
            repeat (2) edge_step(m);
            wr(TMU_IDX_BOARD_COMMAND, TMU_CMD_STOP);
            @(posedge ref_clk);
        end
        $display("edge mode tests done");
        wr(TMU_IDX_TRIG_SRC_SEL, TMU_RISING_EDGE_MODE);
        @(posedge ref_clk);
        wr(TMU_IDX_BOARD_COMMAND, TMU_CMD_START);
        repeat (6) @(posedge ref_clk);
        wr(TMU_IDX_BOARD_COMMAND, TMU_FORCE_TRIGGER_CODE);
        wait_start(0, 1'b1);
        wr(TMU_IDX_BOARD_COMMAND, TMU_FORCE_TRIGGER_CODE);
        wait_start(-1, 1'b0);
        rd(TMU_IDX_STATUS, 32'(1 << TMU_ST_ARMED_BIT | 1 << TMU_ST_RUN_BIT | 1 << TMU_ST_LEVEL_BIT));
        wr(TMU_IDX_TRIG_IN_LOAD, 32'h0);
        rd(TMU_IDX_TRIG_IN_LOAD, 32'h0);
        chk({31'h0, trig_in_load_en}, 32'h0);
        $display("force tests done");
        final_report();
    end
endmodule : tb_trigger_mode_unit
